// ===== rtl/dpd_map.svh
`ifndef DPD_MAP_SVH
`define DPD_MAP_SVH
`define DPD_CLK_HZ 100000000
`define DPD_SAMPLE_HZ 10000000
`define DPD_SAMPLE_DIV (`DPD_CLK_HZ / `DPD_SAMPLE_HZ)
`define DPD_DEG_90 32'h005A0000
`define DPD_DEG_180 32'h00B40000
`define DPD_DEG_270 32'h010E0000
`define DPD_DEG_360 32'h01680000
`define DPD_HZ_TO_INC 18'h25BFB
`define DPD_CORDIC_INV 18'h04DBA
`define DPD_RMS_XY 16'h5A82
`define DPD_RMS_R 16'h36F6
`define DPD_PWR_LO 37'h03E000000
`define DPD_PWR_HI 37'h042000000
`endif

// ===== rtl/dpd_pkg.sv
package dpd_pkg;
   typedef logic signed [31:0] dpd_deg_t;
   typedef logic signed [15:0] dpd_smp_t;
   typedef enum logic [1:0] {
      DPD_REF_INT = 2'b01,
      DPD_REF_EXT = 2'b10
   } dpd_ref_mode_e;
endpackage

// ===== rtl/dpd_demod.sv
// Notes on behaviour
// - the input sample is amplified and multiplied by the reference sine of adjustable phase.
// - each product is averaged by a low-pass filter so only reference-frequency input stays dc.
// - a second multiplier uses the reference advanced by 90 degrees for the quadrature channel.
// - the filtered products are output as in-phase and quadrature components.
// - magnitude is the root of the sum of squares of the two components.
// - phase is the arctangent of quadrature over in-phase.
// - magnitudes are scaled to rms of the detected sine.
// - phase is carried and reported in degrees only.
// - frequency is given in hertz and converted to phase steps internally.
// - with an external reference a phase-locked loop keeps the oscillator at fixed phase.
// - the oscillator gives a variable-amplitude sine and a logic sync, both locked to it.
// - the input is sampled at a fixed rate and multiplied digitally.
`include "dpd_map.svh"

module dpd_cordic #(
   parameter int N = 14,
   parameter int W = 18,
   parameter int TW = 16,
   parameter bit VEC = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic signed [W-1:0] i_x,
   input wire logic signed [W-1:0] i_y,
   input wire logic signed [31:0] i_z,
   input wire logic [TW-1:0] i_tag,
   output logic o_valid,
   output logic signed [W-1:0] o_x,
   output logic signed [W-1:0] o_y,
   output logic signed [31:0] o_z,
   output logic [TW-1:0] o_tag
);
   // angle table in degrees, 16 fraction bits
   function automatic logic signed [31:0] atan_deg(input int i);
      case (i)
         0: atan_deg = 32'sh002D0000;
         1: atan_deg = 32'sh001A90A8;
         2: atan_deg = 32'sh000E0947;
         3: atan_deg = 32'sh00072001;
         4: atan_deg = 32'sh0003938A;
         5: atan_deg = 32'sh0001CA38;
         6: atan_deg = 32'sh0000E52A;
         7: atan_deg = 32'sh00007297;
         8: atan_deg = 32'sh0000394C;
         9: atan_deg = 32'sh00001CA6;
         10: atan_deg = 32'sh00000E53;
         11: atan_deg = 32'sh00000729;
         12: atan_deg = 32'sh00000395;
         13: atan_deg = 32'sh000001CA;
         default: atan_deg = 32'sh00000000;
      endcase
   endfunction

   logic signed [W-1:0] x_ff [0:N];
   logic signed [W-1:0] y_ff [0:N];
   logic signed [31:0] z_ff [0:N];
   logic [TW-1:0] tag_ff [0:N];
   logic vld_ff [0:N];
   logic flip_ff [0:N];

   // fold into the range that converges
   wire logic rot_hi = i_z >= `DPD_DEG_270;
   wire logic rot_mid = i_z > `DPD_DEG_90;
   wire logic neg_x = i_x[W-1];
   wire logic signed [31:0] z_rot = rot_hi ? i_z - `DPD_DEG_360 :
                                    rot_mid ? i_z - `DPD_DEG_180 : i_z;
   wire logic signed [31:0] z_vec = neg_x ? $signed(`DPD_DEG_180) : 32'sh00000000;
   wire logic signed [W-1:0] x0 = (VEC && neg_x) ? -i_x : i_x;
   wire logic signed [W-1:0] y0 = (VEC && neg_x) ? -i_y : i_y;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         x_ff[0] <= '0;
         y_ff[0] <= '0;
         z_ff[0] <= '0;
         tag_ff[0] <= '0;
         vld_ff[0] <= 1'b0;
         flip_ff[0] <= 1'b0;
      end else begin
         x_ff[0] <= x0;
         y_ff[0] <= y0;
         z_ff[0] <= VEC ? z_vec : z_rot;
         tag_ff[0] <= i_tag;
         vld_ff[0] <= i_valid;
         flip_ff[0] <= !VEC && rot_mid && !rot_hi;
      end
   end

   for (genvar k = 0; k < N; k++) begin : g_stage
      wire logic ccw = VEC ? y_ff[k][W-1] : !z_ff[k][31];
      wire logic signed [W-1:0] xs = x_ff[k] >>> k;
      wire logic signed [W-1:0] ys = y_ff[k] >>> k;
      always_ff @(posedge i_clk) begin
         if (!i_rst_n) begin
            x_ff[k+1] <= '0;
            y_ff[k+1] <= '0;
            z_ff[k+1] <= '0;
            tag_ff[k+1] <= '0;
            vld_ff[k+1] <= 1'b0;
            flip_ff[k+1] <= 1'b0;
         end else begin
            x_ff[k+1] <= ccw ? x_ff[k] - ys : x_ff[k] + ys;
            y_ff[k+1] <= ccw ? y_ff[k] + xs : y_ff[k] - xs;
            z_ff[k+1] <= ccw ? z_ff[k] - atan_deg(k) : z_ff[k] + atan_deg(k);
            tag_ff[k+1] <= tag_ff[k];
            vld_ff[k+1] <= vld_ff[k];
            flip_ff[k+1] <= flip_ff[k];
         end
      end
   end

   // wrap the vector angle into (-180, 180]
   wire logic z_over = z_ff[N] > $signed(`DPD_DEG_180);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_valid <= 1'b0;
         o_x <= '0;
         o_y <= '0;
         o_z <= '0;
         o_tag <= '0;
      end else begin
         o_valid <= vld_ff[N];
         o_x <= flip_ff[N] ? -x_ff[N] : x_ff[N];
         o_y <= flip_ff[N] ? -y_ff[N] : y_ff[N];
         o_z <= z_over ? z_ff[N] - `DPD_DEG_360 : z_ff[N];
         o_tag <= tag_ff[N];
      end
   end
endmodule

module dpd_demod #(
   parameter int TC_SHIFT = 8,
   parameter int PLL_KP = 4,
   parameter int PLL_KI = 10
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [15:0] i_adc_data,
   input wire logic [2:0] i_gain_shift,
   input wire logic [19:0] i_freq_hz,
   input wire logic [31:0] i_ref_phase,
   input wire logic i_ext_mode,
   input wire logic i_ext_neg,
   input wire logic i_ext_ref,
   input wire logic [15:0] i_osc_amp,
   output logic o_adc_strobe,
   output logic o_valid,
   output logic signed [17:0] o_x,
   output logic signed [17:0] o_y,
   output logic [17:0] o_r,
   output logic signed [31:0] o_theta,
   output logic signed [15:0] o_osc_sine,
   output logic o_osc_sync
);
   localparam int NSTG = 14;
   localparam int LAT = 2 * NSTG + 8;
   localparam logic [3:0] DIV_LAST = 4'(`DPD_SAMPLE_DIV - 1);

   logic [3:0] div_ff;
   logic samp_ff;
   logic [15:0] adc_s1_ff;
   logic [15:0] adc_s2_ff;
   logic ext_s1_ff;
   logic ext_s2_ff;
   logic ext_s3_ff;
   logic [31:0] acc_ff;
   logic signed [31:0] trim_ff;
   logic signed [31:0] err_ff;
   logic pend_ff;
   dpd_pkg::dpd_smp_t amp_ff;
   logic [31:0] refp_ff;
   logic a_vld_ff;
   logic signed [31:0] prod_i_ff;
   logic signed [31:0] prod_q_ff;
   logic p_vld_ff;
   dpd_pkg::dpd_deg_t fi_ff;
   dpd_pkg::dpd_deg_t fq_ff;
   logic f_vld_ff;

   // fixed sample slot from the core clock
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         div_ff <= '0;
         samp_ff <= 1'b0;
      end else begin
         div_ff <= (div_ff == DIV_LAST) ? 4'h0 : div_ff + 4'h1;
         samp_ff <= (div_ff == DIV_LAST);
      end
   end
   assign o_adc_strobe = samp_ff;

   // converter word arrives from the pins
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         adc_s1_ff <= '0;
         adc_s2_ff <= '0;
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_s3_ff <= 1'b0;
      end else begin
         adc_s1_ff <= i_adc_data;
         adc_s2_ff <= adc_s1_ff;
         ext_s1_ff <= i_ext_ref;
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
      end
   end

   // gain with saturation instead of wrap, so overload clips cleanly
   wire logic signed [23:0] gain_w = 24'($signed(adc_s2_ff)) <<< i_gain_shift;
   wire logic gain_ovf = (gain_w[23:15] != {9{gain_w[23]}});
   wire logic signed [15:0] gain_sat = gain_ovf ? (gain_w[23] ? 16'sh8000 : 16'sh7FFF) :
                                       gain_w[15:0];

   // reference phase = oscillator phase plus user offset, degrees
   wire logic [32:0] refp_sum = {1'b0, acc_ff} + {1'b0, i_ref_phase};
   wire logic [32:0] refp_wrap = refp_sum - {1'b0, `DPD_DEG_360};
   wire logic [31:0] refp_w = (refp_sum >= {1'b0, `DPD_DEG_360}) ? refp_wrap[31:0] :
                              refp_sum[31:0];

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         amp_ff <= '0;
         refp_ff <= '0;
         a_vld_ff <= 1'b0;
      end else begin
         if (samp_ff) begin
            amp_ff <= gain_sat;
            refp_ff <= refp_w;
         end
         a_vld_ff <= samp_ff;
      end
   end

   wire logic rc_vld;
   wire logic signed [17:0] rc_cos;
   wire logic signed [17:0] rc_sin;
   wire logic [15:0] rc_tag;

   dpd_cordic #(.N(NSTG), .W(18), .TW(16), .VEC(1'b0)) u_ref_cordic (
      .i_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_valid(a_vld_ff),
      .i_x($signed(`DPD_CORDIC_INV)),
      .i_y(18'sh00000),
      .i_z($signed(refp_ff)),
      .i_tag(amp_ff),
      .o_valid(rc_vld),
      .o_x(rc_cos),
      .o_y(rc_sin),
      .o_z(),
      .o_tag(rc_tag)
   );

   // sin(p+90) is cos(p), so one rotation gives both channels
   wire logic signed [33:0] pi_w = $signed(rc_tag) * rc_sin;
   wire logic signed [33:0] pq_w = $signed(rc_tag) * rc_cos;

   // filter: y += (p - y) / 2^TC_SHIFT, once per sample
   wire logic signed [32:0] di_w = 33'(prod_i_ff) - 33'(fi_ff);
   wire logic signed [32:0] dq_w = 33'(prod_q_ff) - 33'(fq_ff);
   wire logic signed [32:0] di_s = di_w >>> TC_SHIFT;
   wire logic signed [32:0] dq_s = dq_w >>> TC_SHIFT;
   wire dpd_pkg::dpd_deg_t nxt_fi = fi_ff + di_s[31:0];
   wire dpd_pkg::dpd_deg_t nxt_fq = fq_ff + dq_s[31:0];

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         prod_i_ff <= '0;
         prod_q_ff <= '0;
         p_vld_ff <= 1'b0;
         fi_ff <= '0;
         fq_ff <= '0;
         f_vld_ff <= 1'b0;
      end else begin
         if (rc_vld) begin
            prod_i_ff <= pi_w[31:0];
            prod_q_ff <= pq_w[31:0];
         end
         p_vld_ff <= rc_vld;
         if (p_vld_ff) begin
            fi_ff <= nxt_fi;
            fq_ff <= nxt_fq;
         end
         f_vld_ff <= p_vld_ff;
      end
   end

   wire logic vc_vld;
   wire logic signed [19:0] vc_mag;
   wire logic signed [31:0] vc_z;
   wire logic [35:0] vc_tag;

   // vector rotation yields magnitude and angle of (X, Y)
   dpd_cordic #(.N(NSTG), .W(20), .TW(36), .VEC(1'b1)) u_vec_cordic (
      .i_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_valid(f_vld_ff),
      .i_x({{2{fi_ff[31]}}, fi_ff[31:14]}),
      .i_y({{2{fq_ff[31]}}, fq_ff[31:14]}),
      .i_z(32'sh00000000),
      .i_tag({fi_ff[31:14], fq_ff[31:14]}),
      .o_valid(vc_vld),
      .o_x(vc_mag),
      .o_y(),
      .o_z(vc_z),
      .o_tag(vc_tag)
   );

   // filter top bits [31:14] hold the peak; rms is that over root two
   wire logic signed [34:0] xs_w = $signed(vc_tag[35:18]) * $signed({1'b0, `DPD_RMS_XY});
   wire logic signed [34:0] ys_w = $signed(vc_tag[17:0]) * $signed({1'b0, `DPD_RMS_XY});
   wire logic signed [36:0] rs_w = vc_mag * $signed({1'b0, `DPD_RMS_R});

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_valid <= 1'b0;
         o_x <= '0;
         o_y <= '0;
         o_r <= '0;
         o_theta <= '0;
      end else begin
         o_valid <= vc_vld;
         if (vc_vld) begin
            o_x <= xs_w[32:15];
            o_y <= ys_w[32:15];
            o_r <= rs_w[32:15];
            o_theta <= vc_z;
         end
      end
   end

   // oscillator and phase-locked loop
   wire dpd_pkg::dpd_ref_mode_e ref_mode = i_ext_mode ? dpd_pkg::DPD_REF_EXT :
                                           dpd_pkg::DPD_REF_INT;
   wire logic pll_on = (ref_mode == dpd_pkg::DPD_REF_EXT);
   wire logic ext_edge = i_ext_neg ? (!ext_s2_ff && ext_s3_ff) : (ext_s2_ff && !ext_s3_ff);
   wire logic [37:0] inc_w = i_freq_hz * `DPD_HZ_TO_INC;
   wire logic signed [31:0] err_w = (acc_ff >= `DPD_DEG_180) ? $signed(acc_ff - `DPD_DEG_360) :
                                    $signed(acc_ff);
   wire logic signed [31:0] corr_w = pend_ff ? (err_ff >>> PLL_KP) : 32'sh00000000;
   wire logic signed [33:0] acc_sum = 34'(acc_ff) + 34'(inc_w[37:16]) + 34'(trim_ff) -
                                      34'(corr_w);
   wire logic signed [33:0] acc_hi = acc_sum - 34'(`DPD_DEG_360);
   wire logic signed [33:0] acc_lo = acc_sum + 34'(`DPD_DEG_360);
   // sign first: an unsigned compare would take a negative sum as past a full turn
   wire logic [31:0] nxt_acc = acc_sum[33] ? acc_lo[31:0] :
                               (acc_sum >= 34'(`DPD_DEG_360)) ? acc_hi[31:0] : acc_sum[31:0];

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         acc_ff <= '0;
         trim_ff <= '0;
         err_ff <= '0;
         pend_ff <= 1'b0;
      end else begin
         if (samp_ff) begin
            acc_ff <= nxt_acc;
         end
         if (ext_edge) begin
            err_ff <= err_w;
         end
         // a new edge in the same slot as the update wins over the clear
         pend_ff <= pll_on && (ext_edge || (pend_ff && !samp_ff));
         if (!pll_on) begin
            trim_ff <= '0;
         end else if (samp_ff && pend_ff) begin
            trim_ff <= trim_ff - (err_ff >>> PLL_KI);
         end
      end
   end

   wire logic signed [17:0] oc_sin;

   dpd_cordic #(.N(NSTG), .W(18), .TW(1), .VEC(1'b0)) u_osc_cordic (
      .i_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_valid(samp_ff),
      .i_x($signed(`DPD_CORDIC_INV)),
      .i_y(18'sh00000),
      .i_z($signed(acc_ff)),
      .i_tag(1'b0),
      .o_valid(),
      .o_x(),
      .o_y(oc_sin),
      .o_z(),
      .o_tag()
   );

   wire logic signed [34:0] os_w = oc_sin * $signed({1'b0, i_osc_amp});
   // all ones is full scale, so drop 16 bits; clip the few-lsb rotation overshoot
   wire logic os_ovf = (os_w[34:31] != {4{os_w[34]}});
   wire logic signed [15:0] os_sat = os_ovf ? (os_w[34] ? 16'sh8000 : 16'sh7FFF) :
                                     os_w[31:16];

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_osc_sine <= '0;
         o_osc_sync <= 1'b0;
      end else begin
         o_osc_sine <= os_sat;
         o_osc_sync <= (acc_ff < `DPD_DEG_180);
      end
   end

   // checks
   wire logic signed [36:0] ref_pwr = 37'(rc_sin) * 37'(rc_sin) + 37'(rc_cos) * 37'(rc_cos);
   wire logic [17:0] abs_x = o_x[17] ? 18'(-o_x) : 18'(o_x);
   wire logic [17:0] abs_y = o_y[17] ? 18'(-o_y) : 18'(o_y);

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   AST_SLOT_GAP: assert property (samp_ff |=> !samp_ff [*8])
      else $error("sample slots too close");
   AST_SLOT_PERIOD: assert property (samp_ff |-> ##10 samp_ff)
      else $error("sample slot period wrong");
   AST_LATENCY: assert property (samp_ff |-> ##LAT o_valid)
      else $error("result latency wrong");
   AST_GAIN_SIGN: assert property (a_vld_ff |-> amp_ff[15] == $past(adc_s2_ff[15]))
      else $error("gain changed sample sign");
   AST_FILT_HOLD: assert property (!p_vld_ff |=> $stable(fi_ff) && $stable(fq_ff))
      else $error("filter moved without a product");
   AST_UNIT_REF: assert property (rc_vld |-> ref_pwr >= `DPD_PWR_LO && ref_pwr <= `DPD_PWR_HI)
      else $error("reference pair not unit amplitude");
   AST_MAG_BOUND: assert property (o_valid |-> (o_r + 18'h00010 >= abs_x) &&
                                   (o_r + 18'h00010 >= abs_y))
      else $error("magnitude below a component");
   AST_THETA_RANGE: assert property (o_valid |-> o_theta <= $signed(`DPD_DEG_180) &&
                                     o_theta > -$signed(`DPD_DEG_180))
      else $error("phase outside half turn");
   AST_TRIM_CLR: assert property (!pll_on |=> trim_ff == 32'sh00000000)
      else $error("loop trim kept in internal mode");
   AST_OSC_AMP: assert property ($past(i_osc_amp) == 16'h0000 |-> o_osc_sine == 16'sh0000)
      else $error("sine out with zero amplitude");
endmodule

// ===== testbench/dpd_src.sv
module dpd_src (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_strobe,
   input var real i_amp,
   input var real i_freq,
   input var real i_phase,
   input var int i_ext_half,
   output logic [15:0] o_adc_data,
   output logic o_ext_ref
);
   timeunit 1ns;
   timeprecision 1ps;
   int n = 0;
   int ext_cnt = 0;
   logic take;
   initial begin
      o_adc_data = 16'h0000;
      o_ext_ref = 1'b0;
   end
   // new word just after each slot, so it has settled long before the next one
   always @(posedge i_clk) begin
      take = i_strobe;
      #1;
      if (!i_rst_n) begin
         n = 0;
      end else if (take === 1'b1) begin
         n = n + 1;
         o_adc_data = 16'($rtoi(i_amp * $sin(6.283185307179586 * i_freq * n / 1.0e7
                      + i_phase * 3.141592653589793 / 180.0)));
      end
   end
   // square reference a few ns off the core edge, toggled every i_ext_half core cycles
   always @(posedge i_clk) begin
      #3;
      if (i_ext_half == 0) begin
         o_ext_ref = 1'b0;
      end else begin
         ext_cnt = ext_cnt + 1;
         if (ext_cnt >= i_ext_half) begin
            ext_cnt = 0;
            o_ext_ref = ~o_ext_ref;
         end
      end
   end
endmodule

// ===== testbench/test_dual_phase_demodulator.sv
module test_dual_phase_demodulator;
   timeunit 1ns;
   timeprecision 1ps;
   localparam real PI = 3.141592653589793;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] gain = 3'h0;
   logic [19:0] freq_hz = 20'h3D090;
   logic [31:0] ref_phase = 32'h00000000;
   logic ext_mode = 1'b0;
   logic ext_neg = 1'b0;
   logic [15:0] osc_amp = 16'h8000;
   logic adc_strobe, valid, osc_sync, ext_ref;
   logic [15:0] adc_data;
   logic signed [17:0] x, y;
   logic [17:0] r;
   logic signed [31:0] theta;
   logic signed [15:0] osc_sine;
   real s_amp = 0.0;
   real s_freq = 250000.0;
   real s_phase = 0.0;
   real ax, ay, ar, at;
   real th0 = 0.0;
   int ext_half = 0;
   int seed = 2441;
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0, gap = 0, t_sync = 0, t_edge = 0, sync_gap = 0, sync_d = 0, osc_peak = 0;
   logic [36:0] hist = 37'h0;
   logic r_seen;
   logic sync_prev = 1'b0;
   logic ext_prev = 1'b0;

   // faster loop than the defaults so that lock settles within a short run
   dpd_demod #(.TC_SHIFT(5), .PLL_KP(1), .PLL_KI(6)) dpd_demod_i (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_adc_data(adc_data), .i_gain_shift(gain),
      .i_freq_hz(freq_hz), .i_ref_phase(ref_phase), .i_ext_mode(ext_mode),
      .i_ext_neg(ext_neg), .i_ext_ref(ext_ref), .i_osc_amp(osc_amp),
      .o_adc_strobe(adc_strobe), .o_valid(valid), .o_x(x), .o_y(y), .o_r(r),
      .o_theta(theta), .o_osc_sine(osc_sine), .o_osc_sync(osc_sync));

   dpd_src dpd_src_i (
      .i_clk(clk), .i_rst_n(rst_n), .i_strobe(adc_strobe), .i_amp(s_amp), .i_freq(s_freq),
      .i_phase(s_phase), .i_ext_half(ext_half), .o_adc_data(adc_data), .o_ext_ref(ext_ref));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic check_num(input string name, input real exp, input real got, input real tol);
      comparisons++;
      if (got < exp - tol || got > exp + tol) begin
         err_total++;
         $display("[ERR] %s expected %0.2f seen %0.2f", name, exp, got);
      end
   endtask

   task automatic check_bit(input string name, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task wrap_up;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   function automatic real wrap(input real d);
      real v;
      v = d;
      while (v > 180.0) v -= 360.0;
      while (v <= -180.0) v += 360.0;
      return v;
   endfunction

   // sampled 2 ns after the edge, once every output update has landed
   always @(posedge clk) begin
      r_seen = rst_n;
      #2;
      cyc++;
      hist = {hist[35:0], adc_strobe};
      if (!r_seen) begin
         gap = 0;
         hist = 37'h0;
         check_bit("strobe_in_reset", 1'b0, adc_strobe);
         check_bit("x_zero_in_reset", 1'b1, x === 18'h00000);
      end else begin
         gap++;
         check_bit("valid", hist[36], valid);
         if (adc_strobe === 1'b1) begin
            check_num("strobe_gap", 10.0, gap, 0.0);
            gap = 0;
         end
      end
      if (ext_ref !== ext_prev && ext_ref === ~ext_neg) t_edge = cyc;
      ext_prev = ext_ref;
      if (osc_sync === 1'b1 && sync_prev === 1'b0) begin
         sync_gap = cyc - t_sync;
         t_sync = cyc;
         sync_d = cyc - t_edge;
         if (sync_d > 200) sync_d -= 400;
      end
      sync_prev = osc_sync;
      if ((osc_sine < 0 ? -osc_sine : osc_sine) > osc_peak) begin
         osc_peak = (osc_sine < 0) ? -osc_sine : osc_sine;
      end
   end

   // forty results span whole periods of every ripple term used here
   task automatic measure();
      int k;
      ax = 0.0;
      ay = 0.0;
      ar = 0.0;
      at = 0.0;
      for (int i = 0; i < 40; i++) begin
         k = 0;
         do begin
            @(posedge clk);
            #2;
            k++;
         end while (valid !== 1'b1 && k < 20);
         if (k >= 20) begin
            err_total++;
            $display("[ERR] valid expected 1 seen 0");
         end
         check_bit("result_known", 1'b0, $isunknown({x, y, r, theta}));
         ax += x / 40.0;
         ay += y / 40.0;
         ar += r / 40.0;
         at += theta / 40.0;
      end
   endtask

   task automatic run_case(input real a, input int g, input real sph, input real rph,
                           input real fs, input bit base);
      real m, th, tol;
      @(posedge clk);
      #1;
      gain = 3'(g);
      ref_phase = 32'($rtoi(rph * 65536.0));
      s_amp = a;
      s_freq = fs;
      s_phase = sph;
      repeat (3000) @(posedge clk);
      measure();
      m = (fs == 250000.0) ? a * (2.0 ** g) / $sqrt(2.0) : 0.0;
      tol = 0.02 * m + 40.0;
      if (base) begin
         th0 = at / 65536.0;
         check_num("theta_base", 0.0, th0, 10.0);
      end
      th = wrap(sph - rph + th0);
      check_num("x", m * $cos(th * PI / 180.0), ax, tol);
      check_num("y", m * $sin(th * PI / 180.0), ay, tol);
      if (m > 0.0) begin
         check_num("r", m, ar, tol);
         check_num("theta", th * 65536.0, at, 65536.0);
      end
   endtask

   initial begin
      int ra, rp;
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      run_case(8000.0, 0, 0.0, 0.0, 250000.0, 1'b1);
      run_case(2000.0, 2, 60.0, 0.0, 250000.0, 1'b0);
      run_case(8000.0, 0, -100.0, 0.0, 250000.0, 1'b0);
      run_case(6000.0, 0, 130.0, 30.0, 250000.0, 1'b0);
      run_case(8000.0, 0, 45.0, 45.0, 250000.0, 1'b0);
      run_case(8000.0, 0, 10.0, 350.0, 250000.0, 1'b0);
      run_case(8000.0, 0, 0.0, 0.0, 500000.0, 1'b0);
      for (int i = 0; i < 3; i++) begin
         ra = 3000 + ($unsigned($random(seed)) % 9000);
         rp = $random(seed) % 150;
         run_case(ra, i % 2, rp, 0.0, 250000.0, 1'b0);
      end
      @(posedge clk);
      #1;
      osc_amp = 16'hFFFF;
      repeat (300) @(posedge clk);
      osc_peak = 0;
      repeat (400) @(posedge clk);
      check_num("sync_period", 400.0, sync_gap, 0.0);
      check_num("sine_peak_full", 32767.0, osc_peak, 400.0);
      #1;
      osc_amp = 16'h8000;
      repeat (300) @(posedge clk);
      osc_peak = 0;
      repeat (400) @(posedge clk);
      check_num("sine_peak_half", 16383.0, osc_peak, 300.0);
      #1;
      osc_amp = 16'h0000;
      repeat (30) @(posedge clk);
      osc_peak = 0;
      repeat (400) @(posedge clk);
      check_num("sine_peak_zero", 0.0, osc_peak, 0.0);
      ext_half = 200;
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         #1;
         ext_mode = 1'b1;
         ext_neg = p[0];
         repeat (6000) @(posedge clk);
         repeat (3) begin
            repeat (400) @(posedge clk);
            check_num("pll_offset", 0.0, sync_d, 16.0);
         end
      end
      @(posedge clk);
      #1;
      ext_mode = 1'b0;
      repeat (20) @(posedge clk);
      wrap_up();
   end

   // the full sequence needs about 50k cycles
   initial begin
      #800000;
      err_total++;
      wrap_up();
   end
endmodule
